/* File: design/usp_pkg.sv */
// Purpose: Shared constants for the upstream port register block
// Assumes: 4 KB register block, 32-bit word accesses
// Notes:   Offsets are byte offsets inside the block
package usp_pkg;

  // Block geometry
  localparam int          USP_ADDR_W        = 64;
  localparam int          USP_BASE_LSB      = 12;
  localparam int          USP_OFS_W         = 12;

  // Offsets inside the block
  localparam logic [11:0] USP_OFS_NULL_HDR  = 12'h000;
  localparam logic [11:0] USP_OFS_BASE_LO   = 12'h010;
  localparam logic [11:0] USP_OFS_BASE_HI   = 12'h014;
  localparam logic [11:0] USP_OFS_CAP_PTR   = 12'h034;
  localparam logic [11:0] USP_OFS_EXP_CAP   = 12'h040;
  localparam logic [11:0] USP_OFS_AER       = 12'h100;
  localparam logic [11:0] USP_OFS_MCAST     = 12'h150;
  localparam logic [11:0] USP_OFS_VCH       = 12'h180;
  localparam logic [11:0] USP_OFS_VSC       = 12'h200;
  localparam logic [11:0] USP_OFS_VSC_HDR1  = 12'h004;
  localparam logic [11:0] USP_OFS_VSC_HDR2  = 12'h008;
  localparam logic [11:0] USP_OFS_VCH_CAP1  = 12'h004;

  // Capability identifiers
  localparam logic [15:0] USP_ID_NULL       = 16'h0000;
  localparam logic [7:0]  USP_ID_EXPRESS    = 8'h10;
  localparam logic [15:0] USP_ID_AER        = 16'h0001;
  localparam logic [15:0] USP_ID_VCH        = 16'h0002;
  localparam logic [15:0] USP_ID_MCAST      = 16'h0012;
  localparam logic [15:0] USP_ID_VSC        = 16'h0023;
  localparam logic [3:0]  USP_CAP_VER       = 4'h1;
  localparam logic [3:0]  USP_NULL_VER      = 4'h0;
  localparam logic [7:0]  USP_EXP_VER_WORD  = 8'h02;

  // Vendor capability header fields
  localparam logic [3:0]  USP_VSC_REV       = 4'h0;
  localparam logic [11:0] USP_VSC_LEN       = 12'h010;
  localparam logic [15:0] USP_VSC_ID        = 16'h0007;

  // Channel count field: one extra channel, giving VC0 and VC1
  localparam logic [2:0]  USP_VCH_EXTRA     = 3'h1;

  // Base register: low 12 bits are read-only zero
  localparam logic [31:0] USP_BASE_LO_MASK  = 32'hffff_f000;
  localparam logic [31:0] USP_BASE_RESET    = 32'h0000_0000;

  // Base capture states
  typedef enum logic [2:0]
  {
    USP_ST_DOWN   = 3'b001,
    USP_ST_WAIT   = 3'b010,
    USP_ST_LOCKED = 3'b100
  } usp_state_t;

endpackage

/* File: design/usp_base_capture.sv */
// Purpose: Captures the block base from the first access after link up
// Assumes: link_up is synchronous to clk
// Notes:   Base is released when the link goes down
`timescale 1ns/1ps
`default_nettype none
module usp_base_capture
  import usp_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  link_up,
  input  wire logic                  req_valid,
  input  wire logic [USP_ADDR_W-1:0] req_addr,
  output logic                       base_valid,
  output logic                       first_access,
  output logic [USP_ADDR_W-1:USP_BASE_LSB] base_addr
);

  usp_state_t                        state_reg;
  usp_state_t                        state_next;
  logic [USP_ADDR_W-1:USP_BASE_LSB]  base_reg;
  logic [USP_ADDR_W-1:USP_BASE_LSB]  base_next;

  // Next state and base
  always_comb
  begin
    state_next = state_reg;
    base_next  = base_reg;
    case (state_reg)
      USP_ST_DOWN:
      begin
        if (link_up)
          state_next = USP_ST_WAIT;
      end
      USP_ST_WAIT:
      begin
        if (!link_up)
          state_next = USP_ST_DOWN;
        else if (req_valid)
        begin
          base_next  = req_addr[USP_ADDR_W-1:USP_BASE_LSB];
          state_next = USP_ST_LOCKED;
        end
      end
      USP_ST_LOCKED:
      begin
        if (!link_up)
          state_next = USP_ST_DOWN;
      end
      default:
        state_next = USP_ST_DOWN;
    endcase
  end

  // State registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      state_reg <= USP_ST_DOWN;
      base_reg  <= '0;
    end
    else
    begin
      state_reg <= state_next;
      base_reg  <= base_next;
    end
  end

  assign base_valid   = (state_reg == USP_ST_LOCKED);
  assign first_access = (state_reg == USP_ST_WAIT) && link_up && req_valid;
  assign base_addr    = base_reg;

endmodule
`default_nettype wire

/* File: design/usp_regs.sv */
// Purpose: Upstream port memory-mapped register block with capability chain
// Assumes: One 32-bit aligned word per access; requests synchronous to clk
// Notes:   Read data returns one cycle after the request is taken
`timescale 1ns/1ps
`default_nettype none
module usp_regs
  import usp_pkg::*;
#(
  parameter logic [15:0] VENDOR_ID = 16'h1234  // Arbitrary neutral value
)
(
  input  wire logic                  clk,
  input  wire logic                  rst_n,
  input  wire logic                  link_up,
  input  wire logic                  req_valid,
  input  wire logic                  req_write,
  input  wire logic [USP_ADDR_W-1:0] req_addr,
  input  wire logic [31:0]           req_wdata,
  input  wire logic [3:0]            req_be,
  output logic                       resp_valid,
  output logic [31:0]                resp_rdata,
  output logic                       base_valid,
  output logic [63:0]                component_register_base
);

  logic                              first_access;
  logic [USP_ADDR_W-1:USP_BASE_LSB]  base_addr;
  logic                              hit;
  logic [USP_OFS_W-1:0]              ofs;
  logic [31:0]                       lo_reg;
  logic [31:0]                       lo_next;
  logic [31:0]                       hi_reg;
  logic [31:0]                       hi_next;
  logic                              valid_reg;
  logic                              valid_next;
  logic [31:0]                       rdata_reg;
  logic [31:0]                       rdata_next;
  logic [31:0]                       rd_word;
  logic [31:0]                       be_mask;

  // Block base capture
  usp_base_capture u_base
  (
    .clk          (clk),
    .rst_n        (rst_n),
    .link_up      (link_up),
    .req_valid    (req_valid),
    .req_addr     (req_addr),
    .base_valid   (base_valid),
    .first_access (first_access),
    .base_addr    (base_addr)
  );

  // Address decode: first access or any access inside the captured block
  assign ofs = {req_addr[USP_OFS_W-1:2], 2'b00};
  assign hit = req_valid && (first_access ||
               (base_valid && req_addr[USP_ADDR_W-1:USP_BASE_LSB] == base_addr));
  assign be_mask = {{8{req_be[3]}}, {8{req_be[2]}}, {8{req_be[1]}}, {8{req_be[0]}}};

  // Read multiplexer over the fixed layout
  always_comb
  begin
    rd_word = 32'h0000_0000;
    case (ofs)
      USP_OFS_NULL_HDR:
        rd_word = {USP_OFS_AER, USP_NULL_VER, USP_ID_NULL};
      USP_OFS_BASE_LO:
        rd_word = lo_reg;
      USP_OFS_BASE_HI:
        rd_word = hi_reg;
      USP_OFS_CAP_PTR:
        rd_word = {24'h00_0000, USP_OFS_EXP_CAP[7:0]};
      USP_OFS_EXP_CAP:
        rd_word = {8'h00, USP_EXP_VER_WORD, 8'h00, USP_ID_EXPRESS};
      USP_OFS_AER:
        rd_word = {USP_OFS_MCAST, USP_CAP_VER, USP_ID_AER};
      USP_OFS_MCAST:
        rd_word = {USP_OFS_VCH, USP_CAP_VER, USP_ID_MCAST};
      USP_OFS_VCH:
        rd_word = {USP_OFS_VSC, USP_CAP_VER, USP_ID_VCH};
      USP_OFS_VCH + USP_OFS_VCH_CAP1:
        rd_word = {29'h0000_0000, USP_VCH_EXTRA};
      USP_OFS_VSC:
        rd_word = {12'h000, USP_CAP_VER, USP_ID_VSC};
      USP_OFS_VSC + USP_OFS_VSC_HDR1:
        rd_word = {USP_VSC_LEN, USP_VSC_REV, VENDOR_ID};
      USP_OFS_VSC + USP_OFS_VSC_HDR2:
        rd_word = {16'h0000, USP_VSC_ID};
      default:
        rd_word = 32'h0000_0000;
    endcase
  end

  // Next values: base register writes, read answer
  always_comb
  begin
    lo_next    = lo_reg;
    hi_next    = hi_reg;
    valid_next = hit;
    rdata_next = rdata_reg;
    if (hit && req_write)
    begin
      // Only the base words are writable; all else is dropped
      if (ofs == USP_OFS_BASE_LO)
        lo_next = ((lo_reg & ~be_mask) | (req_wdata & be_mask)) & USP_BASE_LO_MASK;
      else if (ofs == USP_OFS_BASE_HI)
        hi_next = (hi_reg & ~be_mask) | (req_wdata & be_mask);
      rdata_next = 32'h0000_0000;
    end
    else if (hit)
      rdata_next = rd_word;
  end

  // Registers
  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      lo_reg    <= USP_BASE_RESET;
      hi_reg    <= USP_BASE_RESET;
      valid_reg <= 1'b0;
      rdata_reg <= 32'h0000_0000;
    end
    else
    begin
      lo_reg    <= lo_next;
      hi_reg    <= hi_next;
      valid_reg <= valid_next;
      rdata_reg <= rdata_next;
    end
  end

  assign resp_valid              = valid_reg;
  assign resp_rdata              = rdata_reg;
  assign component_register_base = {hi_reg, lo_reg};

endmodule
`default_nettype wire

/* File: dv/usp_regs_chk.sv */
// Purpose: Port assertions for the upstream port register block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every usp_regs instance
`timescale 1ns/1ps
`default_nettype none
module usp_regs_chk
  import usp_pkg::*;
#(parameter logic [15:0] VENDOR_ID = 16'h1234)
(
  input wire logic        clk,
  input wire logic        rst_n,
  input wire logic        link_up,
  input wire logic        req_valid,
  input wire logic        req_write,
  input wire logic [63:0] req_addr,
  input wire logic        resp_valid,
  input wire logic [31:0] resp_rdata,
  input wire logic        base_valid,
  input wire logic [63:0] component_register_base
);
  // Word select and read strobe
  logic [9:0] wd;
  logic       rd;
  assign wd = req_addr[11:2];
  assign rd = req_valid && !req_write;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_answer_has_cause: assert property (resp_valid |-> $past(req_valid))
    else $error("answer without request");
  a_no_link_refused: assert property (rd && !link_up && !base_valid |=> !resp_valid)
    else $error("answer before link up");
  a_first_captures: assert property (req_valid && link_up && $past(link_up) && $past(rst_n)
    && !base_valid |=> base_valid && resp_valid)
    else $error("first access not captured");
  a_write_reads_zero: assert property (resp_valid && $past(req_write) |-> resp_rdata == 32'h0)
    else $error("write answer not zero");
  a_null_word: assert property (resp_valid && $past(rd && wd == 10'h000)
    |-> resp_rdata == 32'h1000_0000)
    else $error("null header wrong");
  a_chain_to_vendor: assert property (resp_valid && $past(rd && wd == 10'h060)
    |-> resp_rdata[31:20] == 12'h200)
    else $error("chain misses vendor cap");
  a_two_channels: assert property (resp_valid && $past(rd && wd == 10'h061)
    |-> resp_rdata[2:0] == 3'h1)
    else $error("channel count wrong");
  a_header_one: assert property (resp_valid && $past(rd && wd == 10'h081)
    |-> resp_rdata == {12'h010, 4'h0, VENDOR_ID})
    else $error("header one wrong");
  a_header_two: assert property (resp_valid && $past(rd && wd == 10'h082)
    |-> resp_rdata == 32'h0000_0007)
    else $error("header two wrong");
  a_base_holds: assert property ($past(rst_n) && !$past(req_valid && req_write)
    |-> $stable(component_register_base) && component_register_base[11:0] == 12'h0)
    else $error("base register changed");
endmodule
bind usp_regs usp_regs_chk #(.VENDOR_ID(VENDOR_ID)) usp_regs_chk_i (.clk(clk), .rst_n(rst_n),
  .link_up(link_up), .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr),
  .resp_valid(resp_valid), .resp_rdata(resp_rdata), .base_valid(base_valid),
  .component_register_base(component_register_base));
`default_nettype wire

/* File: dv/usp_regs_tb_top.sv */
// Purpose: Self-checking bench for the upstream port register block
// Assumes: Inputs driven on the falling edge
// Notes:   Answers are matched in order against a queue
`timescale 1ns/1ps
`default_nettype none
module usp_regs_tb_top;
  import usp_pkg::*;
  localparam logic [15:0] VID = 16'h5a3c; // Arbitrary value
  logic        clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        link_up = 1'b0;
  logic        req_valid = 1'b0;
  logic        req_write = 1'b0;
  logic [63:0] req_addr = 64'h0;
  logic [31:0] req_wdata = 32'h0;
  logic [3:0]  req_be = 4'h0;
  logic        resp_valid;
  logic [31:0] resp_rdata;
  logic        base_valid;
  logic [63:0] component_register_base;
  logic [31:0] q[$];
  logic [51:0] page;
  logic [31:0] rnd = 32'h0001_4934;
  logic [31:0] wl;
  logic [3:0]  be_sel = 4'hf;
  int          n_mismatch = 0;
  int          comparisons = 0;
  logic [11:0] ofs[11] = '{12'h000, 12'h034, 12'h040, 12'h100, 12'h150, 12'h180,
    12'h184, 12'h200, 12'h204, 12'h208, 12'h300};
  logic [31:0] ev[11] = '{32'h1000_0000, 32'h40, 32'h0002_0010, 32'h1501_0001,
    32'h1801_0012, 32'h2001_0002, 32'h1, 32'h0001_0023, {12'h010, 4'h0, VID}, 32'h7, 32'h0};
  usp_regs #(.VENDOR_ID(VID)) usp_regs_i (.clk(clk), .rst_n(rst_n), .link_up(link_up),
    .req_valid(req_valid), .req_write(req_write), .req_addr(req_addr), .req_wdata(req_wdata),
    .req_be(req_be), .resp_valid(resp_valid), .resp_rdata(resp_rdata),
    .base_valid(base_valid), .component_register_base(component_register_base));
  // Clock
  initial
  begin
    forever #10 clk = ~clk;
  end
  // Random source
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction
  task chk(input logic [63:0] s, input logic [63:0] e);
    comparisons++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, s, e);
    end
  endtask
  // One request per call, back to back
  task acc(input logic wr, input logic [63:0] a, input logic [31:0] d, input logic ans,
    input logic [31:0] e);
    @(negedge clk);
    req_valid = 1'b1;
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_be = be_sel;
    if (ans)
      q.push_back(e);
  endtask
  task idle;
    @(negedge clk);
    req_valid = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  task finish_test;
    if (q.size() != 0)
      n_mismatch++;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Answer monitor, mid-cycle while the answer stands
  always @(negedge clk)
    if (resp_valid !== 1'b0)
    begin
      if (q.size() == 0)
        chk(64'h1, 64'h0);
      else
        chk(resp_rdata, q.pop_front());
    end
  // Main sequence
  initial
  begin
    repeat (16) @(negedge clk);
    rst_n = 1'b1;
    rnd = xs(rnd);
    page = {rnd[19:0], rnd};
    acc(1'b0, {page, 12'h000}, 32'h0, 1'b0, 32'h0);
    idle;
    link_up = 1'b1;
    // Header words, the capability pointer, the channel count word and one unmapped word are read
    foreach (ofs[i])
      acc(1'b0, {page, ofs[i]}, 32'h0, 1'b1, ev[i]);
    acc(1'b0, {page + 52'h1, 12'h000}, 32'h0, 1'b0, 32'h0);
    idle;
    chk(base_valid, 1'b1);
    $display("chain test done");
    rnd = xs(rnd);
    wl = rnd;
    rnd = xs(rnd);
    acc(1'b1, {page, 12'h010}, wl, 1'b1, 32'h0);
    acc(1'b1, {page, 12'h014}, rnd, 1'b1, 32'h0);
    acc(1'b1, {page, 12'h208}, wl, 1'b1, 32'h0);
    acc(1'b0, {page, 12'h010}, 32'h0, 1'b1, wl & USP_BASE_LO_MASK);
    acc(1'b0, {page, 12'h014}, 32'h0, 1'b1, rnd);
    acc(1'b0, {page, 12'h208}, 32'h0, 1'b1, 32'h7);
    idle;
    chk(component_register_base, {rnd, wl & USP_BASE_LO_MASK});
    // Low two lanes only: upper half of the high word must keep its value
    be_sel = 4'h3;
    acc(1'b1, {page, 12'h014}, ~rnd, 1'b1, 32'h0);
    be_sel = 4'hf;
    acc(1'b0, {page, 12'h014}, 32'h0, 1'b1, {rnd[31:16], ~rnd[15:0]});
    idle;
    chk(component_register_base[63:32], {rnd[31:16], ~rnd[15:0]});
    $display("base register test done");
    link_up = 1'b0;
    @(negedge clk);
    link_up = 1'b1;
    page = ~page;
    acc(1'b0, {page, 12'h208}, 32'h0, 1'b1, 32'h7);
    idle;
    $display("link restart test done");
    finish_test();
  end
  // Watchdog
  initial
  begin
    #20000;
    n_mismatch++;
    finish_test();
  end
endmodule
`default_nettype wire
